// ### logic/rpt_port_ctrl.sv
// Purpose: Link throttling, debug-port claim and slot events of a port
// Assumes: All inputs synchronous to clock; APB slave, zero wait state
// Notes:   Throttle timers count in microsecond ticks
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/10ps
module rpt_port_ctrl #(
  parameter int LANES = 4
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  severityIn,
  input  wire logic [1:0]  linkState,
  output logic             blockRequests,
  output logic             holdCredits,
  input  wire logic        ioReq,
  input  wire logic [15:0] ioAddr,
  output logic             debugClaim,
  input  wire logic        presenceIn,
  input  wire logic        linkActiveIn,
  input  wire logic        separate_refclk_mode,
  output logic             l0sAllowed,
  output logic             lowSkipAllowed,
  input  wire logic [LANES-1:0] rxPolarityBad,
  input  wire logic        trainingActive,
  output logic [LANES-1:0] rxInvert,
  input  wire logic        reverseReq,
  input  wire logic [1:0]  laneConfig,
  output logic [1:0]       laneMap [LANES],
  output logic             slotIrqLevel,
  output logic             slotMsiPulse,
  output logic             system_mgmt_interrupt_out
);
  import rpt_pkg::*;

  if (LANES != 4) begin : g_lanes_check
    $error("rpt_port_ctrl serves four lanes only");
  end

  typedef struct packed {
    logic [31:0]      rcfg;
    logic [31:0]      mcfg;
    logic [31:0]      sctl;
    logic             presState;
    logic             presChg;
    logic             linkChg;
    logic             sciSts;
    logic             smiPres;
    logic             smiLink;
    logic             presSeen;
    logic             linkSeen;
    logic [3:0]       sevSeen;
    logic             enSeen;
    logic             wasL1;
    logic [7:0]       tick;
    logic [15:0]      winCnt;
    logic             irqSeen;
    logic             msiPulse;
    logic [31:0]      rdata;
    logic             claim;
    logic [LANES-1:0] inv;
    logic             reversed;
  } rpt_state_s;

  rpt_state_s state_reg, state_next;

  function automatic logic [1:0] sevLevel(input logic [3:0] sev);
    sevLevel = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (sev[i]) sevLevel = 2'(i);
    end
  endfunction

  logic        apbWr;
  logic        apbRd;
  logic        throttleEn;
  logic [1:0]  lvl;
  logic [15:0] zoneLen;
  logic [15:0] winLen;
  logic        inZone;
  logic        timersRun;
  logic        presEvt;
  logic        linkEvt;
  logic        w1cSlot;
  logic        w1cSmi;
  logic        irqNow;

  assign apbWr      = psel && penable && pwrite;
  assign apbRd      = psel && !pwrite;
  assign throttleEn = state_reg.rcfg[RC_EN_BIT];
  assign lvl        = sevLevel(severityIn);
  assign zoneLen    = 16'(state_reg.rcfg[RC_ZONE_LSB +: 8]
                      * state_reg.rcfg[RC_MULT_LSB + 2*lvl +: 2]);
  assign winLen     = {8'h00, state_reg.rcfg[RC_PERIOD_LSB +: 8]};
  assign timersRun  = (linkState == LNK_ACTIVE);
  assign inZone     = throttleEn && (state_reg.winCnt < zoneLen);
  assign presEvt    = presenceIn != state_reg.presSeen;
  assign linkEvt    = linkActiveIn != state_reg.linkSeen;
  assign w1cSlot    = apbWr && paddr == OFS_SLOT_STS;
  assign w1cSmi     = apbWr && paddr == OFS_SMI_SCI_STS;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next          = state_reg;
    state_next.msiPulse = 1'b0;
    state_next.claim    = 1'b0;
    // Register writes
    if (apbWr && paddr == OFS_RESTRICT_CFG) begin
      state_next.rcfg = pwdata;
    end else if (apbWr && paddr == OFS_MISC_CFG) begin
      state_next.mcfg = pwdata;
    end else if (apbWr && paddr == OFS_SLOT_CTL) begin
      state_next.sctl = pwdata;
    end
    // Throttle window timing
    state_next.sevSeen = severityIn;
    state_next.enSeen  = throttleEn;
    state_next.wasL1   = (linkState == LNK_L1);
    if (!throttleEn) begin
      state_next.winCnt = 16'h0000;
      state_next.tick   = 8'h00;
    end else if ((severityIn != state_reg.sevSeen) || !state_reg.enSeen
                 || (state_reg.wasL1 && linkState != LNK_L1)) begin
      state_next.winCnt = 16'h0000;
      state_next.tick   = 8'h00;
    end else if (timersRun) begin
      if (state_reg.tick == 8'(TICK_CYCLES - 1)) begin
        state_next.tick = 8'h00;
        if (state_reg.winCnt + 16'h0001 >= winLen) begin
          state_next.winCnt = 16'h0000;
        end else begin
          state_next.winCnt = state_reg.winCnt + 16'h0001;
        end
      end else begin
        state_next.tick = state_reg.tick + 8'h01;
      end
    end
    // Slot events: set wins over a write-one clear
    state_next.presSeen = presenceIn;
    state_next.linkSeen = linkActiveIn;
    if (w1cSlot && pwdata[SS_PRES_CHG]) state_next.presChg = 1'b0;
    if (w1cSlot && pwdata[SS_LINK_CHG]) state_next.linkChg = 1'b0;
    if (w1cSmi && pwdata[SS_SCI])       state_next.sciSts  = 1'b0;
    if (w1cSmi && pwdata[SS_SMI_PRES])  state_next.smiPres = 1'b0;
    if (w1cSmi && pwdata[SS_SMI_LINK])  state_next.smiLink = 1'b0;
    if (presEvt) begin
      state_next.presState = presenceIn;
      state_next.presChg   = 1'b1;
      if (state_reg.mcfg[MC_SMI_EN]) state_next.smiPres = 1'b1;
    end
    if (linkEvt) begin
      state_next.linkChg = 1'b1;
      if (state_reg.mcfg[MC_SMI_EN]) state_next.smiLink = 1'b1;
    end
    if (state_reg.mcfg[MC_SCI_EN] && state_reg.sctl[SC_HP_IE]
        && ((presEvt && state_reg.sctl[SC_PRES_IE])
         || (linkEvt && state_reg.sctl[SC_LINK_IE]))) begin
      state_next.sciSts = 1'b1;
    end
    // Message on each new rise of pending interrupt
    state_next.irqSeen = irqNow;
    if (irqNow && !state_reg.irqSeen && state_reg.mcfg[MC_MSI_EN]) begin
      state_next.msiPulse = 1'b1;
    end
    // Debug port claim, base/limit not consulted
    if (ioReq && state_reg.mcfg[MC_DEBUG_DEC]
        && ioAddr >= 16'h0080 && ioAddr <= 16'h008f) begin
      state_next.claim = 1'b1;
    end
    // Polarity learned per lane during training
    for (int i = 0; i < LANES; i++) begin
      if (trainingActive && rxPolarityBad[i]) begin
        state_next.inv[i] = !state_reg.inv[i];
      end
    end
    if (trainingActive) begin
      state_next.reversed = reverseReq
        && (laneConfig == LANE_1X4 || laneConfig == LANE_2X1_1X2);
    end
    // Read data
    state_next.rdata = 32'h0000_0000;
    if (apbRd) begin
      if (paddr == OFS_RESTRICT_CFG) begin
        state_next.rdata = state_reg.rcfg;
      end else if (paddr == OFS_MISC_CFG) begin
        state_next.rdata = state_reg.mcfg;
      end else if (paddr == OFS_SLOT_CTL) begin
        state_next.rdata = state_reg.sctl;
      end else if (paddr == OFS_SLOT_STS) begin
        state_next.rdata[SS_PRES_CHG]   = state_reg.presChg;
        state_next.rdata[SS_PRES_STATE] = state_reg.presState;
        state_next.rdata[SS_LINK_CHG]   = state_reg.linkChg;
      end else if (paddr == OFS_SMI_SCI_STS) begin
        state_next.rdata[SS_SCI]      = state_reg.sciSts;
        state_next.rdata[SS_SMI_PRES] = state_reg.smiPres;
        state_next.rdata[SS_SMI_LINK] = state_reg.smiLink;
      end else if (paddr == OFS_LINK_CAP) begin
        state_next.rdata[L1_EXIT_LSB +: 3] = separate_refclk_mode
          ? L1_EXIT_10US : L1_EXIT_NORMAL;
        state_next.rdata[L0S_SUP_BIT] = !separate_refclk_mode;
      end else if (paddr == OFS_LINK_STAT) begin
        state_next.rdata[15:0] = state_reg.winCnt;
        state_next.rdata[16]   = inZone;
        state_next.rdata[17]   = state_reg.reversed;
        state_next.rdata[18 +: LANES] = state_reg.inv;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg      <= '0;
      state_reg.rcfg <= RESTRICT_CFG_RST;
      state_reg.mcfg <= MISC_CFG_RST;
      state_reg.sctl <= SLOT_CTL_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Level stays up while any enabled status bit is pending
  assign irqNow = state_reg.sctl[SC_HP_IE]
    && ((state_reg.presChg && state_reg.sctl[SC_PRES_IE])
     || (state_reg.linkChg && state_reg.sctl[SC_LINK_IE]));

  // Setup cycle fetches read data, so access completes with no wait
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = state_reg.rdata;

  assign blockRequests  = inZone;
  assign holdCredits    = inZone;
  assign slotIrqLevel   = irqNow && !state_reg.mcfg[MC_MSI_EN];
  assign slotMsiPulse   = state_reg.msiPulse;
  assign debugClaim     = state_reg.claim;
  assign l0sAllowed     = !separate_refclk_mode;
  assign lowSkipAllowed = 1'b0;
  assign rxInvert       = state_reg.inv;
  assign system_mgmt_interrupt_out =
    state_reg.smiPres || state_reg.smiLink;

  // Reversal mirrors lane i onto lane LANES-1-i
  for (genvar g = 0; g < LANES; g++) begin : g_map
    assign laneMap[g] = state_reg.reversed ? 2'(LANES - 1 - g) : 2'(g);
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_sevChange;
    throttleEn && severityIn != $past(severityIn);
  endsequence

  property p_winRestart;
    @(posedge clock) disable iff (!rst_n)
      s_sevChange |=> state_reg.winCnt == 16'h0000;
  endproperty
  a_winRestart: assert property (p_winRestart)
    else $error("window not restarted on severity change");

  property p_idleOff;
    @(posedge clock) disable iff (!rst_n)
      !throttleEn |-> !blockRequests && !holdCredits;
  endproperty
  a_idleOff: assert property (p_idleOff)
    else $error("throttle active while disabled");

  property p_freezeL1;
    @(posedge clock) disable iff (!rst_n)
      (linkState == LNK_L1 && throttleEn && state_reg.enSeen
       && severityIn == state_reg.sevSeen) |=> $stable(state_reg.winCnt);
  endproperty
  a_freezeL1: assert property (p_freezeL1)
    else $error("timer moved in L1");

  property p_presSet;
    @(posedge clock) disable iff (!rst_n)
      presEvt |=> state_reg.presChg && state_reg.presState == $past(presenceIn);
  endproperty
  a_presSet: assert property (p_presSet)
    else $error("presence event not recorded");

  property p_smi;
    @(posedge clock) disable iff (!rst_n)
      (presEvt && state_reg.mcfg[MC_SMI_EN]) |=> ##0
        system_mgmt_interrupt_out;
  endproperty
  a_smi: assert property (p_smi)
    else $error("management interrupt missing");

  property p_claim;
    @(posedge clock) disable iff (!rst_n)
      (ioReq && state_reg.mcfg[MC_DEBUG_DEC] && ioAddr[15:4] == 12'h008)
        |=> debugClaim;
  endproperty
  a_claim: assert property (p_claim)
    else $error("debug port access not claimed");

  property p_sciSet;
    @(posedge clock) disable iff (!rst_n)
      (presEvt && state_reg.mcfg[MC_SCI_EN] && state_reg.sctl[SC_HP_IE]
       && state_reg.sctl[SC_PRES_IE]) |=> state_reg.sciSts;
  endproperty
  a_sciSet: assert property (p_sciSet)
    else $error("SCI status not set");

  property p_srisCap;
    @(posedge clock) disable iff (!rst_n)
      (apbRd && paddr == OFS_LINK_CAP && separate_refclk_mode)
        |=> prdata[L1_EXIT_LSB +: 3] == L1_EXIT_10US && !prdata[L0S_SUP_BIT];
  endproperty
  a_srisCap: assert property (p_srisCap)
    else $error("wrong L1 exit latency advertised");

endmodule // rpt_port_ctrl

// ### pkg/rpt_pkg.sv
// Purpose: Constants for the root port throttle and hot-plug block
// Assumes: 250 MHz core clock, APB register access
// Notes:   Offsets are byte addresses of 32-bit words
package rpt_pkg;
  localparam int          CLK_MHZ          = 250;
  localparam logic [11:0] OFS_RESTRICT_CFG = 12'h000;
  localparam logic [11:0] OFS_MISC_CFG     = 12'h004;
  localparam logic [11:0] OFS_SLOT_CTL     = 12'h008;
  localparam logic [11:0] OFS_SLOT_STS     = 12'h00c;
  localparam logic [11:0] OFS_SMI_SCI_STS  = 12'h010;
  localparam logic [11:0] OFS_LINK_CAP     = 12'h014;
  localparam logic [11:0] OFS_LINK_STAT    = 12'h018;
  // link_restrict_config fields
  localparam int RC_EN_BIT     = 0;
  localparam int RC_ZONE_LSB   = 8;
  localparam int RC_PERIOD_LSB = 16;
  localparam int RC_MULT_LSB   = 24;
  // misc_port_config fields
  localparam int MC_DEBUG_DEC  = 0;
  localparam int MC_SCI_EN     = 1;
  localparam int MC_SMI_EN     = 2;
  localparam int MC_MSI_EN     = 3;
  // slot control / status fields
  localparam int SC_PRES_IE    = 0;
  localparam int SC_HP_IE      = 1;
  localparam int SC_LINK_IE    = 2;
  localparam int SS_PRES_CHG   = 0;
  localparam int SS_PRES_STATE = 1;
  localparam int SS_LINK_CHG   = 2;
  // smi_sci_status_reg fields
  localparam int SS_SCI        = 0;
  localparam int SS_SMI_PRES   = 1;
  localparam int SS_SMI_LINK   = 2;
  localparam logic [31:0] RESTRICT_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] MISC_CFG_RST     = 32'h0000_0000;
  localparam logic [31:0] SLOT_CTL_RST     = 32'h0000_0000;
  // L1 exit latency field codes in the link capability word
  localparam logic [2:0]  L1_EXIT_NORMAL   = 3'h2;
  localparam logic [2:0]  L1_EXIT_10US     = 3'h6;
  localparam int          L1_EXIT_LSB      = 15;
  localparam int          L0S_SUP_BIT      = 10;
  // Time base of the zone and window counts
  localparam int          TICK_NS          = 1000;
  localparam int          TICK_CYCLES      = TICK_NS * CLK_MHZ / 1000;
  localparam int          RESPONSE_US      = 100;
  // Link power states seen by the timers
  localparam logic [1:0]  LNK_ACTIVE       = 2'h0;
  localparam logic [1:0]  LNK_L1           = 2'h1;
  localparam logic [1:0]  LNK_L23RDY       = 2'h2;
  localparam logic [1:0]  LNK_DOWN         = 2'h3;
  // Lane configurations
  localparam logic [1:0]  LANE_1X4         = 2'h0;
  localparam logic [1:0]  LANE_2X1_1X2     = 2'h1;
endpackage

// ### tb/root_port_throttle_hotplug_bench.sv
// Purpose: Self-checking bench of the port control block
// Assumes: Zero wait state APB, throttle tick of 250 cycles
// Notes:   Expectations come from integer models of the rules
`timescale 1ns/10ps
module root_port_throttle_hotplug_bench;
  import rpt_pkg::*;
  logic        clock, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  severityIn, rxPolarityBad, rxInvert;
  logic [1:0]  linkState, laneConfig;
  logic [1:0]  laneMap [4];
  logic        blockRequests, holdCredits, ioReq, debugClaim, presenceIn;
  logic        linkActiveIn, separate_refclk_mode, l0sAllowed;
  logic        lowSkipAllowed, trainingActive, reverseReq, slotIrqLevel;
  logic        slotMsiPulse, system_mgmt_interrupt_out, plugReq, linkReq;
  logic [15:0] ioAddr;
  logic [7:0]  debugValue, lastVal;
  int          mismatches, num_checks, hi, a;
  rpt_port_ctrl rpt_port_ctrl_inst (.clock(clock), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .severityIn(severityIn), .linkState(linkState),
    .blockRequests(blockRequests), .holdCredits(holdCredits),
    .ioReq(ioReq), .ioAddr(ioAddr), .debugClaim(debugClaim),
    .presenceIn(presenceIn), .linkActiveIn(linkActiveIn),
    .separate_refclk_mode(separate_refclk_mode), .l0sAllowed(l0sAllowed),
    .lowSkipAllowed(lowSkipAllowed), .rxPolarityBad(rxPolarityBad),
    .trainingActive(trainingActive), .rxInvert(rxInvert),
    .reverseReq(reverseReq), .laneConfig(laneConfig), .laneMap(laneMap),
    .slotIrqLevel(slotIrqLevel), .slotMsiPulse(slotMsiPulse),
    .system_mgmt_interrupt_out(system_mgmt_interrupt_out));
  rpt_endpoint_model rpt_endpoint_model_inst (.clock(clock), .rst_n(rst_n),
    .plugReq(plugReq), .linkReq(linkReq), .ioWrite(1'b1),
    .debugClaim(debugClaim), .ioData(ioAddr[7:0]), .presenceIn(presenceIn),
    .linkActiveIn(linkActiveIn), .debugValue(debugValue));
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic complete_run;
    if (mismatches == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      mismatches++;
    end
  endtask
  // Holds the request until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] ad,
                     input logic [31:0] d, output logic [31:0] q);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #(4 * 60000);
    mismatches++;
    complete_run();
  end
  initial begin
    {psel, penable, pwrite, ioReq, plugReq, linkReq} = '0;
    {paddr, pwdata, ioAddr, severityIn, linkState} = '0;
    {separate_refclk_mode, rxPolarityBad, trainingActive} = '0;
    {reverseReq, laneConfig} = '0;
    mismatches = 0;
    num_checks = 0;
    rst_n = 1'b0;
    void'($urandom(58837));
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    apb(0, OFS_RESTRICT_CFG, 0, rd); chk("restrict cfg", 0, rd);
    apb(0, 12'h07c, 0, rd);          chk("unmapped", 0, rd);
    apb(1, 12'h07c, 32'hffff_ffff, rd);
    apb(0, OFS_RESTRICT_CFG, 0, rd); chk("unmapped write", 0, rd);
    apb(0, OFS_LINK_CAP, 0, rd);
    chk("l1 exit", {29'h0, L1_EXIT_NORMAL}, {29'h0, rd[17:15]});
    chk("l0s", 1, l0sAllowed);
    separate_refclk_mode <= 1'b1;
    apb(0, OFS_LINK_CAP, 0, rd);
    chk("l1 exit separate_refclk_mode", {29'h0, L1_EXIT_10US}, {29'h0, rd[17:15]});
    chk("l0s separate_refclk_mode", 0, l0sAllowed);
    chk("low skip", 0, lowSkipAllowed);
    // Disabled throttle must never block
    apb(1, OFS_RESTRICT_CFG, 32'h7906_0100, rd);
    hi = 0;
    repeat (600) @(posedge clock) hi += blockRequests;
    chk("idle block", 0, hi);
    // Multipliers 1,2,3,1 for levels 0..3; zone 1 tick, window 6 ticks
    apb(1, OFS_RESTRICT_CFG, 32'h7906_0101, rd);
    for (int lvl = 3; lvl >= 0; lvl--) begin
      severityIn <= 4'h1 << lvl;
      @(posedge clock);
      @(posedge clock);
      hi = 0;
      repeat (6 * TICK_CYCLES - 4) @(posedge clock) begin
        hi += blockRequests;
        if (holdCredits !== blockRequests) chk("credits", 0, 1);
      end
      a = ((32'h79 >> (2 * lvl)) & 3) * TICK_CYCLES;
      chk("zone len", 1, (hi >= a - 3 && hi <= a) ? 1 : 0);
    end
    chk("zone end", 0, blockRequests);
    // L1 freezes the window; leaving L1 restarts it with a fresh zone
    linkState <= LNK_L1;
    hi = 0;
    repeat (300) @(posedge clock) hi += blockRequests;
    chk("l1 frozen", 0, hi);
    linkState <= LNK_ACTIVE;
    hi = 0;
    repeat (300) @(posedge clock) hi += blockRequests;
    a = (hi >= TICK_CYCLES - 3 && hi <= TICK_CYCLES) ? 1 : 0;
    chk("l1 restart", 1, a);
    apb(1, OFS_RESTRICT_CFG, 0, rd);
    // Port 8x claim on random addresses near the range
    apb(1, OFS_MISC_CFG, 32'h7, rd);
    lastVal = 8'h00;
    repeat (40) begin
      a = 16'h0070 + ($urandom % 48);
      ioAddr <= a[15:0];
      ioReq  <= 1'b1;
      @(posedge clock);
      ioReq  <= 1'b0;
      @(negedge clock);
      chk("claim", (a >= 32'h80 && a <= 32'h8f), debugClaim);
      if (a >= 32'h80 && a <= 32'h8f) lastVal = a[7:0];
      @(negedge clock);
      chk("port value", lastVal, debugValue);
      @(posedge clock);
    end
    // Slot events: insertion, removal, link change
    apb(1, OFS_SLOT_CTL, 32'h3, rd);
    plugReq <= 1'b1;
    repeat (4) @(posedge clock);
    apb(0, OFS_SLOT_STS, 0, rd); chk("insert sts", 3, rd & 7);
    chk("irq level", 1, slotIrqLevel);
    apb(0, OFS_SMI_SCI_STS, 0, rd); chk("smi sts", 3, rd & 3);
    chk("smi out", 1, system_mgmt_interrupt_out);
    apb(1, OFS_SLOT_STS, 32'h7, rd);
    apb(1, OFS_SMI_SCI_STS, 32'h7, rd);
    chk("smi clear", 0, system_mgmt_interrupt_out);
    chk("irq clear", 0, slotIrqLevel);
    plugReq <= 1'b0;
    linkReq <= 1'b1;
    repeat (4) @(posedge clock);
    apb(0, OFS_SLOT_STS, 0, rd); chk("remove sts", 1, rd & 3);
    apb(0, OFS_SMI_SCI_STS, 0, rd); chk("smi link", 6, rd & 6);
    chk("smi out link", 1, system_mgmt_interrupt_out);
    // Message mode: one pulse per new rise of pending, wire held low
    apb(1, OFS_MISC_CFG, 32'hf, rd);
    apb(1, OFS_SLOT_STS, 32'h7, rd);
    plugReq <= 1'b1;
    hi = 0;
    repeat (6) @(posedge clock) hi += slotMsiPulse;
    chk("msi pulses", 1, hi);
    chk("msi wire", 0, slotIrqLevel);
    // Polarity and lane reversal while training
    a = $urandom % 16;
    rxPolarityBad  <= a[3:0];
    trainingActive <= 1'b1;
    reverseReq     <= 1'b1;
    @(posedge clock);
    rxPolarityBad  <= 4'h0;
    repeat (3) @(posedge clock);
    chk("invert", a, rxInvert);
    for (int c = 0; c < 4; c++) begin
      laneConfig <= 2'(c);
      @(posedge clock);
      @(posedge clock);
      hi = (c == LANE_1X4 || c == LANE_2X1_1X2) ? 1 : 0;
      for (int g = 0; g < 4; g++) begin
        chk("lane map", hi ? 3 - g : g, laneMap[g]);
      end
    end
    trainingActive <= 1'b0;
    repeat (4) @(posedge clock);
    complete_run();
  end
endmodule // root_port_throttle_hotplug_bench

// ### tb/rpt_endpoint_model.sv
// Purpose: Downstream endpoint seen by the port: slot levels, port 8x store
// Assumes: Bench asks for plug and link changes at clock edges
// Notes:   Levels move one edge after the request, as a real detector would
`timescale 1ns/10ps
module rpt_endpoint_model (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        plugReq,
  input  wire logic        linkReq,
  input  wire logic        ioWrite,
  input  wire logic        debugClaim,
  input  wire logic [7:0]  ioData,
  output logic             presenceIn,
  output logic             linkActiveIn,
  output logic      [7:0]  debugValue
);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      presenceIn   <= 1'b0;
      linkActiveIn <= 1'b0;
      debugValue   <= 8'h00;
    end else begin
      presenceIn   <= plugReq;
      linkActiveIn <= linkReq;
      // debugValue holds the last value written on a claimed access
      if (debugClaim && ioWrite) begin
        debugValue <= ioData;
      end
    end
  end
endmodule // rpt_endpoint_model
